// ---- common/dco_pkg.sv ----
package dco_pkg;
	// ----------------------------------------
	// register map and field layout
	// ----------------------------------------
	localparam logic [7:0] DCO_WR_OPCODE = 8'h3E;
	localparam logic [7:0] DCO_RD_OPCODE = 8'hBE;
	localparam logic [7:0] DCO_REG_OFFSET = 8'h3E;
	localparam logic [15:0] DCO_RESET_VALUE = 16'h0000;
	localparam int DCO_RET_MSB = 15;
	localparam int DCO_RET_LSB = 8;
	localparam int DCO_RSVD_BIT = 7;
	localparam int DCO_DET_MSB = 6;
	localparam logic [15:0] DCO_WRITE_MASK = 16'hFF7F;
	// ----------------------------------------
	// comparator level: supply * (base + code) / step_div
	// ----------------------------------------
	localparam logic signed [11:0] DCO_LEVEL_BASE = 12'sh480;
	localparam logic [11:0] DCO_LEVEL_DIV = 12'hC00;

	typedef enum logic [1:0] {
		DCO_IDLE = 2'b01,
		DCO_WAIT = 2'b10
	} dco_phase_e;

	typedef struct packed {
		logic [15:0] value;
	} dco_reg_s;

	typedef struct packed {
		logic signed [11:0] level;
		logic returned;
	} dco_cmp_s;
endpackage

// ---- sim/dco_host.sv ----
`timescale 1ns/10ps
// host side of the serial command link
module dco_host (
	input wire logic clk_sys,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [15:0] cmd_wdata
);
	// idle link at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one-cycle command strobe launched off the falling edge
	task automatic send(input logic [7:0] op, input logic [15:0] d);
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_opcode = op;
		cmd_wdata = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		cmd_wdata = ~d; // stale data never left on the line
	endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import dco_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, flash_load = 1'b0, pol = 1'b0;
	logic meas_start = 1'b0, early = 1'b0, meas_done = 1'b0;
	logic [15:0] flash_data = 16'h0000;
	logic cmd_valid, rd_valid, cmp_returned;
	logic [7:0] cmd_opcode;
	logic [15:0] cmd_wdata, rd_data, flash_image;
	logic signed [11:0] cmp_level;
	int num_errors = 0, checked = 0;
	// ----------------------------------------
	// clock, host and device
	// ----------------------------------------
	always #10 clk_sys = ~clk_sys;
	dco_host host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_wdata(cmd_wdata));
	dco_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata), .flash_load(flash_load),
		.flash_data(flash_data), .stop_edge_polarity(pol), .meas_start(meas_start),
		.early_edge_found(early), .meas_done(meas_done), .rd_data(rd_data),
		.rd_valid(rd_valid), .cmp_level(cmp_level), .cmp_returned(cmp_returned),
		.flash_image(flash_image));
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// expected comparator level for a signed offset
	function automatic logic [15:0] lvl(input int off);
		return {4'h0, 12'(1152 + off)};
	endfunction
	task automatic pulse(ref logic s);
		@(negedge clk_sys);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	// read back and compare, rd_valid seen one cycle after the strobe
	task automatic rd(input logic [15:0] exp);
		host.send(DCO_RD_OPCODE, 16'h0000);
		check("rd_valid", {15'h0, rd_valid}, 16'h0001);
		check("rd_data", rd_data, exp);
		@(negedge clk_sys);
		check("rd_valid_end", {15'h0, rd_valid}, 16'h0000);
	endtask
	task automatic t_reg;
		rd(16'h0000);
		check("level", {4'h0, cmp_level}, lvl(0));
		host.send(DCO_WR_OPCODE, 16'hFFFF);
		rd(16'hFF7F);
		check("image", flash_image, 16'hFF7F);
		host.send(8'h3F, 16'h0000);
		rd(16'hFF7F);
		flash_data = 16'h1234;
		pulse(flash_load);
		rd(16'h1234);
	endtask
	task automatic t_detect(input logic p);
		pol = p;
		host.send(DCO_WR_OPCODE, 16'h807F);
		@(negedge clk_sys);
		check("detect", {4'h0, cmp_level}, lvl(p ? -127 : 127));
	endtask
	task automatic t_return(input logic [7:0] r);
		pol = 1'b0;
		host.send(DCO_WR_OPCODE, {r, 8'h05});
		pulse(meas_start);
		check("ret0", {15'h0, cmp_returned}, 16'h0000);
		check("det", {4'h0, cmp_level}, lvl(5));
		pulse(early);
		check("ret1", {15'h0, cmp_returned}, 16'h0001);
		check("rlev", {4'h0, cmp_level}, lvl(int'($signed(r))));
		pulse(meas_done);
		check("ret2", {15'h0, cmp_returned}, 16'h0001);
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		t_reg();
		t_detect(1'b0);
		t_detect(1'b1);
		t_return(8'h7F);
		t_return(8'h80);
		t_return(8'hFF);
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		#20000;
		num_errors++;
		end_of_test();
	end
endmodule

// ---- verilog/dco_store.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// flash-backed register cell
// ----------------------------------------
module dco_store (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic load_en,
	input wire logic [15:0] load_data,
	output dco_pkg::dco_reg_s stored
);
	import dco_pkg::*;

	dco_reg_s state_q;
	dco_reg_s state_d;

	// masked write keeps the reserved bit clear
	always_comb begin
		state_d = state_q;
		if (load_en) begin
			state_d.value = load_data & DCO_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= '{value: DCO_RESET_VALUE};
		end else begin
			state_q <= state_d;
		end
	end

	assign stored = state_q;

	a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!state_q.value[DCO_RSVD_BIT]) else $error("reserved bit set");
endmodule

// ---- verilog/dco_top.sv ----
// Summary of operation
// - after the early edge, comparator switches from detect offset to return offset
// - return offset bits 15:8 read as a signed two's-complement count
// - level code equals 1152 plus signed code, in steps of supply/3072
// - unsigned 7-bit detect offset in bits 6:0 used during early-edge detection
// - stop polarity 0 makes the detect offset positive
// - stop polarity 1 makes the detect offset negative
`timescale 1ns/10ps
module dco_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [15:0] cmd_wdata,
	input wire logic flash_load,
	input wire logic [15:0] flash_data,
	input wire logic stop_edge_polarity,
	input wire logic meas_start,
	input wire logic early_edge_found,
	input wire logic meas_done,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic signed [11:0] cmp_level,
	output logic cmp_returned,
	output logic [15:0] flash_image
);
	import dco_pkg::*;

	// ----------------------------------------
	// register cell
	// ----------------------------------------
	dco_reg_s stored;
	logic wr_hit;
	logic load_en;
	logic [15:0] load_data;

	// write opcode or flash recall loads the cell
	assign wr_hit = cmd_valid && (cmd_opcode == DCO_WR_OPCODE);
	assign load_en = wr_hit || flash_load;
	assign load_data = wr_hit ? cmd_wdata : flash_data;

	dco_store u_store (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.load_en(load_en),
		.load_data(load_data),
		.stored(stored)
	);

	// ----------------------------------------
	// sequencing and outputs
	// ----------------------------------------
	// everything remembered apart from the register cell
	typedef struct packed {
		dco_phase_e phase;
		dco_cmp_s cmp;
		logic [15:0] rdata;
		logic rvalid;
		logic [15:0] image;
	} dco_state_s;

	// current and next copies of the state
	dco_state_s st_q;
	dco_state_s st_d;
	logic signed [11:0] det_signed;
	logic signed [11:0] ret_signed;

	// signed offsets from the stored fields
	always_comb begin
		det_signed = {5'h00, stored.value[DCO_DET_MSB:0]};
		if (stop_edge_polarity) begin
			det_signed = -det_signed;
		end
		ret_signed = {{4{stored.value[DCO_RET_MSB]}},
			stored.value[DCO_RET_MSB:DCO_RET_LSB]};
	end

	// phase machine picks which offset drives the comparator
	always_comb begin
		st_d = st_q;
		// read strobe lasts one cycle
		st_d.rvalid = 1'b0;
		st_d.image = stored.value;
		// read opcode latches the register
		if (cmd_valid && (cmd_opcode == DCO_RD_OPCODE)) begin
			st_d.rdata = stored.value;
			st_d.rvalid = 1'b1;
		end
		// measurement phase
		case (st_q.phase)
			DCO_IDLE: begin
				if (meas_start) begin
					st_d.phase = DCO_WAIT;
				end
			end
			DCO_WAIT: begin
				if (meas_done) begin
					st_d.phase = DCO_IDLE;
				end else if (early_edge_found) begin
					st_d.cmp.returned = 1'b1;
				end
			end
			default: st_d.phase = DCO_IDLE;
		endcase
		// a new measurement starts on the detect offset
		if (meas_start && st_q.phase == DCO_IDLE) begin
			st_d.cmp.returned = 1'b0;
		end
		// level code relative to supply/3072
		if (st_d.cmp.returned) begin
			st_d.cmp.level = DCO_LEVEL_BASE + ret_signed;
		end else begin
			st_d.cmp.level = DCO_LEVEL_BASE + det_signed;
		end
	end

	// async clear: idle, detect offset of a zero register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q.phase <= DCO_IDLE;
			st_q.cmp.level <= DCO_LEVEL_BASE;
			st_q.cmp.returned <= 1'b0;
			st_q.rdata <= 16'h0000;
			st_q.rvalid <= 1'b0;
			st_q.image <= DCO_RESET_VALUE;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state flops
	assign rd_data = st_q.rdata;
	assign rd_valid = st_q.rvalid;
	assign cmp_level = st_q.cmp.level;
	assign cmp_returned = st_q.cmp.returned;
	assign flash_image = st_q.image;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// switch-over from detect offset to return offset
	a_return_switch: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_WAIT && early_edge_found && !meas_done) |=> cmp_returned)
		else $error("no switch to return offset");
	a_return_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_WAIT && cmp_returned) |=> cmp_returned)
		else $error("return offset dropped while measuring");
	a_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_IDLE && !meas_start) |=> cmp_returned == $past(cmp_returned))
		else $error("offset choice changed while idle");
	a_done_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_WAIT && meas_done) |=>
		(st_q.phase == DCO_IDLE && cmp_returned == $past(cmp_returned)))
		else $error("measurement end not taken");
	a_start_measure: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_IDLE && meas_start) |=> st_q.phase == DCO_WAIT)
		else $error("measurement start not taken");
	a_phase_onehot: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$onehot(st_q.phase))
		else $error("phase code not one-hot");

	// return offset level, signed code around the common-mode base
	a_return_sign: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cmp_returned && $stable(stored.value) && $past(cmp_returned)) |->
		cmp_level == DCO_LEVEL_BASE + $signed({{4{stored.value[15]}}, stored.value[15:8]}))
		else $error("return level wrong");
	a_level_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		cmp_level >= 12'sh400 && cmp_level <= 12'sh4FF)
		else $error("level out of range");

	// detect offset level and its sign
	a_detect_pos: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!cmp_returned && $past(!stop_edge_polarity) && $stable(stored.value)) |->
		cmp_level == DCO_LEVEL_BASE + $signed({5'h00, stored.value[6:0]}))
		else $error("positive detect level wrong");
	a_detect_neg: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!cmp_returned && $past(stop_edge_polarity) && $stable(stored.value)) |->
		cmp_level == DCO_LEVEL_BASE - $signed({5'h00, stored.value[6:0]}))
		else $error("negative detect level wrong");
	a_detect_use: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_q.phase == DCO_IDLE && meas_start) |=> !cmp_returned)
		else $error("detect offset not used at start");
	a_detect_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!cmp_returned |-> (cmp_level >= 12'sh401 && cmp_level <= 12'sh4FF))
		else $error("detect level out of range");

	// register commands, recall and flash image
	a_read_back: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cmd_valid && cmd_opcode == DCO_RD_OPCODE) |=> rd_valid && rd_data == $past(stored.value))
		else $error("read data wrong");
	a_read_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!(cmd_valid && cmd_opcode == DCO_RD_OPCODE) |=> !rd_valid)
		else $error("read strobe too long");
	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!(cmd_valid && cmd_opcode == DCO_RD_OPCODE) |=> $stable(rd_data))
		else $error("read data moved without a read");
	a_rsvd_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_valid |-> !rd_data[DCO_RSVD_BIT])
		else $error("reserved bit read back set");
	a_write_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(cmd_valid && cmd_opcode == DCO_WR_OPCODE) |=>
		stored.value == ($past(cmd_wdata) & DCO_WRITE_MASK))
		else $error("write not stored");
	a_flash_recall: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(flash_load && !(cmd_valid && cmd_opcode == DCO_WR_OPCODE)) |=>
		stored.value == ($past(flash_data) & DCO_WRITE_MASK))
		else $error("flash recall not stored");
	a_reg_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!flash_load && !(cmd_valid && cmd_opcode == DCO_WR_OPCODE)) |=>
		$stable(stored.value))
		else $error("register changed without a load");
	a_image_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
		flash_image == $past(stored.value))
		else $error("flash image does not follow the register");

	// main scenarios reached
	c_switch: cover property (@(posedge clk_sys) disable iff (!rst_b)
		!cmp_returned ##1 cmp_returned);
	c_neg_detect: cover property (@(posedge clk_sys) disable iff (!rst_b)
		stop_edge_polarity && !cmp_returned && stored.value[6:0] != 7'h00);
	c_neg_return: cover property (@(posedge clk_sys) disable iff (!rst_b)
		cmp_returned && stored.value[15]);
	c_recall: cover property (@(posedge clk_sys) disable iff (!rst_b)
		flash_load && !cmd_valid);
	c_done_return: cover property (@(posedge clk_sys) disable iff (!rst_b)
		st_q.phase == DCO_WAIT && meas_done && cmp_returned);
endmodule
